// ---- rtl/ccd_defs.svh ----
/*
 * Constants of the card command terminal controller: command codes,
 * fixed parameter values, status words, register map and field positions.
 * Assumes inclusion by bare name from rtl/ files only.
 */
`ifndef CCD_DEFS_SVH
`define CCD_DEFS_SVH

`define CCD_CLASS       8'ha0
`define CCD_INS_UPD_BIN 8'hd6
`define CCD_INS_RD_REC  8'hb2
`define CCD_INS_UPD_REC 8'hdc
`define CCD_INS_SEARCH  8'ha2
`define CCD_INS_INCR    8'h32
`define CCD_INS_VERIFY  8'h20
`define CCD_INS_CHANGE  8'h24
`define CCD_INS_DISABLE 8'h26
`define CCD_INS_ENABLE  8'h28
`define CCD_INS_UNBLOCK 8'h2c
`define CCD_INS_INVAL   8'h04
`define CCD_INS_REHAB   8'h44
`define CCD_INS_AUTH    8'h88
`define CCD_INS_SLEEP   8'hfa
`define CCD_INS_RETR    8'hc0
`define CCD_INS_CAPAB   8'h10
`define CCD_INS_RESULT  8'h14
`define CCD_INS_CMDA    8'hc2
`define CCD_INS_FETCH   8'h12
`define CCD_MODE_NEXT   8'h02
`define CCD_MODE_PREV   8'h03
`define CCD_MODE_ABS    8'h04
`define CCD_ZERO        8'h00
`define CCD_CODE_ONE    8'h01
`define CCD_CODE_TWO    8'h02
`define CCD_LEN_INCR    8'h03
`define CCD_LEN_CODE    8'h08
`define CCD_LEN_PAIR    8'h10
`define CCD_SW_OK1      8'h90
`define CCD_SW_OK2      8'h00
`define CCD_SW_PEND     8'h9f
`define CCD_SW_SEC      8'h98
`define CCD_SW_MAX      8'h50
`define CCD_SW_REF      8'h94
`define CCD_SW_RANGE    8'h02
`define CCD_HDR_BYTES   3'h5
`define CCD_REG_CTRL    8'h00
`define CCD_REG_HDR     8'h04
`define CCD_REG_WDATA   8'h08
`define CCD_REG_RDATA   8'h0c
`define CCD_REG_STAT    8'h10
`define CCD_REG_PEND    8'h14
`define CCD_CTRL_START  0
`define CCD_CTRL_CLEAR  1
`endif

// ---- rtl/ccd_pkg.sv ----
/*
 * Types of the card command terminal controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ccd_pkg;
    // direction of the data phase of a command
    typedef enum logic [1:0] {DIR_NONE, DIR_IN, DIR_OUT} ccd_dir_e;
    // sequencer states
    typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_DOUT, ST_DIN, ST_SW1, ST_SW2} ccd_state_e;
    typedef logic [7:0] ccd_byte_t;
endpackage

// ---- rtl/ccd_buf_if.sv ----
/*
 * Interface between the sequencer and its byte store.
 * Assumes one clock domain; the store reads combinationally.
 */
`timescale 1ns/1ps
`default_nettype none
interface ccd_buf_if;
    logic       wrEn;   // write strobe
    logic [7:0] wrIdx;  // write index
    logic [7:0] wrData; // write byte
    logic [7:0] rdIdx;  // read index
    logic [7:0] rdData; // read byte
    modport owner (output wrEn, output wrIdx, output wrData, output rdIdx, input rdData);
    modport store (input wrEn, input wrIdx, input wrData, input rdIdx, output rdData);
endinterface
`default_nettype wire

// ---- rtl/ccd_byte_buf.sv ----
/*
 * Flip-flop byte store shared by command data and response data.
 * Assumes the owner never writes and reads one index for the same purpose.
 */
`timescale 1ns/1ps
`default_nettype none
module ccd_byte_buf import ccd_pkg::*; #(
    parameter int DEPTH = 256
) (
    // clock, reset, enable
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    // access port
    ccd_buf_if.store  bus
);
    ccd_byte_t mem_q [DEPTH]; // storage

    // one write per cycle; a frozen clock enable also freezes storage
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) mem_q[i] <= 8'h00;
        end else if (ce && bus.wrEn) begin
            mem_q[bus.wrIdx] <= bus.wrData;
        end
    end

    assign bus.rdData = mem_q[bus.rdIdx]; // combinational read
endmodule // ccd_byte_buf
`default_nettype wire

// ---- rtl/ccd_hdr_check.sv ----
/*
 * Command header checker: legality, data direction, effective P1.
 * Assumes header fields are stable while sampled.
 */
`timescale 1ns/1ps
`include "ccd_defs.svh"
`default_nettype none
module ccd_hdr_check import ccd_pkg::*; (
    // header fields
    input  wire ccd_byte_t ins,
    input  wire ccd_byte_t p1,
    input  wire ccd_byte_t p2,
    input  wire ccd_byte_t p3,
    // verdict
    output var  logic      legal,
    output var  ccd_dir_e  dir,
    output var  ccd_byte_t p1Eff
);
    logic p12z; // P1 and P2 both zero
    logic recMode; // valid record mode
    always_comb begin
        p12z    = (p1 == `CCD_ZERO) && (p2 == `CCD_ZERO);
        recMode = (p2 == `CCD_MODE_NEXT) || (p2 == `CCD_MODE_PREV) || (p2 == `CCD_MODE_ABS);
        legal   = 1'b0;
        dir     = DIR_NONE;
        // relative modes send P1 as 00 whatever software wrote
        p1Eff   = ((ins == `CCD_INS_RD_REC || ins == `CCD_INS_UPD_REC) && p2 != `CCD_MODE_ABS) ? `CCD_ZERO : p1;
        case (ins)
            `CCD_INS_UPD_BIN: begin legal = 1'b1; dir = DIR_IN; end
            `CCD_INS_RD_REC:  begin legal = recMode; dir = DIR_OUT; end
            `CCD_INS_UPD_REC: begin legal = recMode; dir = DIR_IN; end
            `CCD_INS_SEARCH:  begin
                legal = (p1 == `CCD_ZERO) && (p2[7:4] <= 4'h1) && (p2[3:0] <= 4'h3);
                dir   = DIR_IN;
            end
            `CCD_INS_INCR:    begin legal = p12z && p3 == `CCD_LEN_INCR; dir = DIR_IN; end
            `CCD_INS_VERIFY:  begin
                legal = p1 == `CCD_ZERO && (p2 == `CCD_CODE_ONE || p2 == `CCD_CODE_TWO) && p3 == `CCD_LEN_CODE;
                dir   = DIR_IN;
            end
            `CCD_INS_CHANGE:  begin
                legal = p1 == `CCD_ZERO && (p2 == `CCD_CODE_ONE || p2 == `CCD_CODE_TWO) && p3 == `CCD_LEN_PAIR;
                dir   = DIR_IN;
            end
            `CCD_INS_DISABLE,
            `CCD_INS_ENABLE:  begin
                legal = p1 == `CCD_ZERO && p2 == `CCD_CODE_ONE && p3 == `CCD_LEN_CODE;
                dir   = DIR_IN;
            end
            `CCD_INS_UNBLOCK: begin
                legal = p1 == `CCD_ZERO && (p2 == `CCD_ZERO || p2 == `CCD_CODE_TWO) && p3 == `CCD_LEN_PAIR;
                dir   = DIR_IN;
            end
            `CCD_INS_INVAL,
            `CCD_INS_REHAB,
            `CCD_INS_SLEEP:   begin legal = p12z && p3 == `CCD_ZERO; end
            `CCD_INS_AUTH:    begin legal = p12z && p3 == `CCD_LEN_PAIR; dir = DIR_IN; end
            `CCD_INS_RETR:    begin legal = p12z; dir = DIR_OUT; end
            `CCD_INS_CAPAB,
            `CCD_INS_RESULT:  begin legal = p12z; dir = DIR_IN; end
            `CCD_INS_CMDA:    begin legal = p12z; dir = DIR_IN; end
            `CCD_INS_FETCH:   begin legal = p12z; dir = DIR_OUT; end
            default:          begin legal = 1'b0; end
        endcase
    end
endmodule // ccd_hdr_check
`default_nettype wire

// ---- rtl/ccd_terminal_ctrl.sv ----
/*
 * Terminal-side card command controller. Software writes a command
 * header and data bytes over APB and starts it; the controller checks the
 * header, sends class, instruction and parameters and data to the card
 * byte link, collects outbound data and the two status bytes, and keeps
 * track of whether a response retrieval is currently allowed.
 * Assumes a byte link with valid/ready towards the card and a plain valid
 * strobe from the card, both synchronous to sys_clk; the card answers
 * every command with exactly P3 data bytes (outbound) then two status bytes.
 */
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "ccd_defs.svh"
`default_nettype none
module ccd_terminal_ctrl import ccd_pkg::*; #(
    parameter int DEPTH = 256 // byte store size, covers P3 up to 255
) (
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // byte link towards the card
    output var  logic [7:0]  cardTxByte,
    output var  logic        cardTxValid,
    input  wire logic        cardTxReady,
    input  wire logic [7:0]  cardRxByte,
    input  wire logic        cardRxValid,
    // status levels
    output var  logic        busy,
    output var  logic        cmdDone
);
    // apb answer registers
    logic [31:0] prdata_q;       // read data
    logic        pready_q;       // access completion
    logic        pslverr_q;      // unmapped address
    // command state
    ccd_state_e  state_q;        // sequencer state
    logic [31:0] hdr_q;          // {p3, p2, p1, ins}
    logic [7:0]  cnt_q;          // bytes moved in this phase
    ccd_dir_e    dir_q;          // data direction latched at start
    logic [7:0]  p1Lat_q;        // effective P1 latched at start
    // link output registers
    logic [7:0]  txByte_q;       // byte offered to the card
    logic        txValid_q;      // offer pending
    // software buffer pointers
    logic [7:0]  swWrPtr_q;      // next byte software loads
    logic [7:0]  swRdPtr_q;      // next response byte software reads
    // result registers
    ccd_byte_t   sw1_q;          // first status byte
    ccd_byte_t   sw2_q;          // second status byte
    logic        pendValid_q;    // card holds data for retrieval
    logic [7:0]  pendLen_q;      // length announced by the card
    logic        firstCmd_q;     // no command sent since reset
    logic        doneFlag_q;     // sticky: command finished
    logic        rejFlag_q;      // sticky: command refused locally

    // decoded header
    logic        hdrLegal;       // header passes the checker
    ccd_dir_e    hdrDir;         // data direction
    ccd_byte_t   hdrP1Eff;       // P1 as it goes on the link

    ccd_buf_if   bufBus ();      // byte store port

    ccd_hdr_check u_check (
        .ins   (hdr_q[7:0]),
        .p1    (hdr_q[15:8]),
        .p2    (hdr_q[23:16]),
        .p3    (hdr_q[31:24]),
        .legal (hdrLegal),
        .dir   (hdrDir),
        .p1Eff (hdrP1Eff)
    );

    ccd_byte_buf #(.DEPTH(DEPTH)) u_buf (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .bus     (bufBus)
    );

    // bus strobes
    logic apbAccess;  // access phase before the answer
    logic apbDone;    // edge at which the master samples pready high
    logic wrDone;     // completing write
    logic rdDone;     // completing read
    logic startReq;   // software asks to start
    logic clearReq;   // software clears sticky flags
    logic retrOk;     // a response retrieval may go out now
    logic startGo;    // command accepted
    logic startRej;   // command refused
    logic txFree;     // output slot empty or being taken
    logic [7:0] p3;   // length field

    assign apbAccess = psel && penable && !pready_q;
    assign apbDone   = psel && penable && pready_q;
    assign wrDone    = apbDone && pwrite;
    assign rdDone    = apbDone && !pwrite;
    assign startReq  = wrDone && paddr == `CCD_REG_CTRL && pwdata[`CCD_CTRL_START];
    assign clearReq  = wrDone && paddr == `CCD_REG_CTRL && pwdata[`CCD_CTRL_CLEAR];
    assign p3        = hdr_q[31:24];
    // retrieval only right after a command that left data, or first of all
    assign retrOk    = pendValid_q || firstCmd_q;
    assign startGo   = startReq && state_q == ST_IDLE && hdrLegal &&
                       (hdr_q[7:0] != `CCD_INS_RETR || retrOk);
    // refused headers never reach the card, so no card data is touched
    assign startRej  = startReq && state_q == ST_IDLE && !startGo;
    assign txFree    = !txValid_q || cardTxReady;

    // picks the header byte at a given position
    function automatic ccd_byte_t hdrByte(input logic [7:0] idx);
        case (idx)
            8'h00:   hdrByte = `CCD_CLASS;
            8'h01:   hdrByte = hdr_q[7:0];
            8'h02:   hdrByte = p1Lat_q;
            8'h03:   hdrByte = hdr_q[23:16];
            default: hdrByte = p3;
        endcase
    endfunction

    // store port: card data while receiving, sequencer reads while sending, software otherwise
    always_comb begin
        bufBus.wrEn   = 1'b0;
        bufBus.wrIdx  = swWrPtr_q;
        bufBus.wrData = pwdata[7:0];
        if (state_q == ST_DIN) begin
            bufBus.wrEn   = cardRxValid;
            bufBus.wrIdx  = cnt_q;
            bufBus.wrData = cardRxByte;
        end else if (wrDone && paddr == `CCD_REG_WDATA && state_q == ST_IDLE) begin
            bufBus.wrEn   = 1'b1;
        end
        bufBus.rdIdx = (state_q == ST_DOUT) ? cnt_q : swRdPtr_q;
    end

    // apb answer: one wait state, then pready for a single cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (ce) begin
            pready_q  <= apbAccess;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            if (apbAccess) begin
                case (paddr)
                    `CCD_REG_CTRL:  prdata_q <= {30'h0, state_q != ST_IDLE, 1'b0};
                    `CCD_REG_HDR:   prdata_q <= hdr_q;
                    `CCD_REG_WDATA: prdata_q <= {24'h0, swWrPtr_q};
                    `CCD_REG_RDATA: prdata_q <= {24'h0, bufBus.rdData};
                    `CCD_REG_STAT:  begin
                        // decoded status classes next to the raw bytes
                        prdata_q <= {8'h0,
                            sw1_q == `CCD_SW_REF && sw2_q == `CCD_SW_RANGE,
                            sw1_q == `CCD_SW_SEC && sw2_q == `CCD_SW_MAX,
                            sw1_q == `CCD_SW_PEND,
                            sw1_q == `CCD_SW_OK1 && sw2_q == `CCD_SW_OK2,
                            rejFlag_q, doneFlag_q, firstCmd_q, pendValid_q,
                            sw1_q, sw2_q};
                    end
                    `CCD_REG_PEND:  prdata_q <= {24'h0, pendLen_q};
                    default:        pslverr_q <= 1'b1; // unmapped address
                endcase
            end
        end
    end

    // header register, writable only while idle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hdr_q <= 32'h0000_0000;
        end else if (ce && wrDone && paddr == `CCD_REG_HDR && state_q == ST_IDLE) begin
            hdr_q <= pwdata;
        end
    end

    // software pointers: a start rewinds both so data lines up from index 0
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            swWrPtr_q <= 8'h00;
            swRdPtr_q <= 8'h00;
        end else if (ce) begin
            if (startGo) begin
                swWrPtr_q <= 8'h00;
                swRdPtr_q <= 8'h00;
            end else begin
                if (wrDone && paddr == `CCD_REG_WDATA && state_q == ST_IDLE)
                    swWrPtr_q <= swWrPtr_q + 8'h01;
                if (rdDone && paddr == `CCD_REG_RDATA)
                    swRdPtr_q <= swRdPtr_q + 8'h01;
            end
        end
    end

    // sequencer: header, data phase, two status bytes
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cnt_q   <= 8'h00;
            dir_q   <= DIR_NONE;
            p1Lat_q <= 8'h00;
        end else if (ce) begin
            case (state_q)
                ST_IDLE: begin
                    if (startGo) begin
                        state_q <= ST_HDR;
                        cnt_q   <= 8'h00;
                        dir_q   <= hdrDir;
                        p1Lat_q <= hdrP1Eff;
                    end
                end
                ST_HDR: begin
                    // leave only once the last header byte was taken
                    if (txFree && cnt_q == {5'h0, `CCD_HDR_BYTES}) begin
                        cnt_q <= 8'h00;
                        if (p3 == 8'h00 || dir_q == DIR_NONE) state_q <= ST_SW1;
                        else if (dir_q == DIR_IN)             state_q <= ST_DOUT;
                        else                                  state_q <= ST_DIN;
                    end else if (txFree) begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                ST_DOUT: begin
                    if (txFree && cnt_q == p3) begin
                        state_q <= ST_SW1;
                        cnt_q   <= 8'h00;
                    end else if (txFree) begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                ST_DIN: begin
                    if (cardRxValid) begin
                        cnt_q <= cnt_q + 8'h01;
                        if (cnt_q == p3 - 8'h01) state_q <= ST_SW1;
                    end
                end
                ST_SW1: begin
                    if (cardRxValid) state_q <= ST_SW2;
                end
                ST_SW2: begin
                    if (cardRxValid) state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // link output: a byte stays offered until the card takes it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txByte_q  <= 8'h00;
            txValid_q <= 1'b0;
        end else if (ce && txFree) begin
            txValid_q <= 1'b0;
            if (state_q == ST_HDR && cnt_q != {5'h0, `CCD_HDR_BYTES}) begin
                txByte_q  <= hdrByte(cnt_q);
                txValid_q <= 1'b1;
            end else if (state_q == ST_DOUT && cnt_q != p3) begin
                txByte_q  <= bufBus.rdData;
                txValid_q <= 1'b1;
            end
        end
    end

    // status bytes from the card
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sw1_q <= 8'h00;
            sw2_q <= 8'h00;
        end else if (ce && cardRxValid) begin
            if (state_q == ST_SW1) sw1_q <= cardRxByte;
            if (state_q == ST_SW2) sw2_q <= cardRxByte;
        end
    end

    // retrieval bookkeeping; any accepted command ends the pending window
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pendValid_q <= 1'b0;
            pendLen_q   <= 8'h00;
            firstCmd_q  <= 1'b1;
        end else if (ce) begin
            if (startGo) begin
                pendValid_q <= 1'b0;
                firstCmd_q  <= 1'b0;
            end else if (state_q == ST_SW2 && cardRxValid && sw1_q == `CCD_SW_PEND) begin
                pendValid_q <= 1'b1;
                pendLen_q   <= cardRxByte;
            end
        end
    end

    // sticky flags; a setting event wins over a clear in the same cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            doneFlag_q <= 1'b0;
            rejFlag_q  <= 1'b0;
        end else if (ce) begin
            if (state_q == ST_SW2 && cardRxValid) doneFlag_q <= 1'b1;
            else if (clearReq || startGo)         doneFlag_q <= 1'b0;
            if (startRej)                         rejFlag_q  <= 1'b1;
            else if (clearReq || startGo)         rejFlag_q  <= 1'b0;
        end
    end

    // status level outputs, registered like the rest
    logic busy_q;    // command in flight
    logic cmdDone_q; // copy of the done flag
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q    <= 1'b0;
            cmdDone_q <= 1'b0;
        end else if (ce) begin
            busy_q    <= (state_q != ST_IDLE) || startGo;
            cmdDone_q <= doneFlag_q;
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign cardTxByte  = txByte_q;
    assign cardTxValid = txValid_q;
    assign busy        = busy_q;
    assign cmdDone     = cmdDone_q;
endmodule // ccd_terminal_ctrl
`default_nettype wire

// ---- test/ccd_terminal_ctrl_asserts.sv ----
/* port checker of the terminal controller
   assumes a bind into ccd_terminal_ctrl, one clock */
`timescale 1ns/1ps
`default_nettype none
module ccd_terminal_ctrl_asserts (
    input wire logic       sys_clk, sys_rst, psel, penable, pready, pslverr,
    input wire logic [7:0] paddr, cardTxByte,
    input wire logic       cardTxValid, cardTxReady, busy, cmdDone
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_ready_wait: assert property ($rose(psel && penable) |=> pready) else $error("ready late");
    a_ready_once: assert property (pready |=> !pready) else $error("ready held");
    a_err_map: assert property (pready && paddr > 8'h14 |-> pslverr) else $error("no error");
    a_ok_map: assert property (pready && paddr < 8'h15 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("bad error");
    a_err_pair: assert property (pslverr |-> pready) else $error("lone error");
    a_tx_hold: assert property (cardTxValid && !cardTxReady |=>
        cardTxValid && $stable(cardTxByte)) else $error("tx moved");
    a_class_first: assert property ($rose(busy) |-> ##[0:2]
        (cardTxValid && cardTxByte == 8'ha0)) else $error("no class");
    a_tx_busy: assert property (cardTxValid |-> ##[0:1] busy) else $error("tx idle");
    a_done_end: assert property ($fell(busy) |-> ##[0:2] cmdDone) else $error("no done");
    c_cmd: cover property ($rose(busy));
    c_stall: cover property (cardTxValid && !cardTxReady);
    c_err: cover property (pslverr);
endmodule // ccd_terminal_ctrl_asserts
`default_nettype wire

// ---- test/ccd_card_model.sv ----
/* card model: takes header and data, answers data then status
   assumes the byte link runs on sys_clk */
`timescale 1ns/1ps
`default_nettype none
module ccd_card_model (
    input  wire logic       sys_clk, sys_rst, cardTxValid,
    input  wire logic [7:0] cardTxByte,
    output var  logic       cardTxReady, cardRxValid,
    output var  logic [7:0] cardRxByte
);
    logic [7:0] h[5]; // header as taken
    int         n, k; // bytes taken, bytes answered
    logic       out;  // data flows to the terminal
    assign out = h[1] inside {8'hb2, 8'hc0, 8'h12};
    logic [15:0] sw; // status word: pending data, refused increase, bad offset, or plain success
    assign sw = h[1] == 8'h88 ? 16'h9f0c : h[1] == 8'ha2 && h[3][7:4] == 4'h1 ? 16'h9f01 :
        h[1] == 8'h32 ? 16'h9850 : h[1] == 8'hd6 ? 16'h9402 : 16'h9000;
    // random stalls; answer only once every inbound byte is in
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            n <= 0; k <= 0; cardTxReady <= 1'b0; cardRxValid <= 1'b0; cardRxByte <= 8'h00;
        end else begin
            cardTxReady <= 1'($urandom_range(1, 0));
            cardRxValid <= 1'b0;
            cardRxByte <= ~cardRxByte; // never leave the last byte standing
            if (cardTxValid && cardTxReady) begin
                if (n < 5) h[n] <= cardTxByte;
                n <= n + 1;
            end else if (n >= 5 && n == 5 + (out ? 0 : int'(h[4]))) begin
                cardRxValid <= 1'b1;
                k <= k + 1;
                if (out && k < h[4]) cardRxByte <= h[1] ^ k[7:0];
                else if (k == (out ? int'(h[4]) : 0)) cardRxByte <= sw[15:8];
                else begin
                    cardRxByte <= sw[7:0];
                    n <= 0; k <= 0;
                end
            end
        end
    end
endmodule // ccd_card_model
`default_nettype wire

// ---- test/ccd_terminal_ctrl_tb.sv ----
/* bench: terminal controller against the card model
   assumes rtl/ and the checker compiled first */
`timescale 1ns/1ps
`default_nettype none
module ccd_terminal_ctrl_tb;
    logic        sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic        cardTxValid, cardTxReady, cardRxValid, busy, cmdDone;
    logic [7:0]  paddr = 0, cardTxByte, cardRxByte, txq[$];
    logic [31:0] pwdata = 0, prdata;
    int          errors = 0, checks_done = 0;
    logic        pend = 1; // retrieval allowed as first command
    // {legal, p3, p2, p1, ins}
    logic [32:0] cmds[] = '{33'h1040000c0, 33'h1032001d6, 33'h1030405b2, 33'h1030233b2, 33'h1020377dc,
        33'h1021200a2, 33'h1010000c0, 33'h103000032, 33'h108010020, 33'h110020024, 33'h108010026, 33'h108010028,
        33'h11000002c, 33'h11002002c, 33'h100000004, 33'h100000044, 33'h1000000fa, 33'h102000010,
        33'h102000014, 33'h1020000c2, 33'h102000012, 33'h110000088, 33'h10c0000c0, 33'h108010020,
        33'h1040000c0, 33'h007010020, 33'h0040000b0, 33'h008020026, 33'h0000000a1};
    ccd_terminal_ctrl DUT (.sys_clk, .sys_rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cardTxByte, .cardTxValid, .cardTxReady, .cardRxByte, .cardRxValid, .busy, .cmdDone);
    ccd_card_model u_card (.sys_clk, .sys_rst, .cardTxValid, .cardTxByte, .cardTxReady, .cardRxValid, .cardRxByte);
    initial forever #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (cardTxValid && cardTxReady) txq.push_back(cardTxByte);
    task automatic check(string n, logic [31:0] s, logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk) penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        r = prdata; psel <= 0; penable <= 0;
        @(posedge sys_clk);
    endtask
    task automatic run(logic [32:0] c);
        logic [7:0] ins, p2, p3, q[$];
        logic [31:0] r, st;
        logic [15:0] x; // status word the card is to give
        bit acc, o;
        {p3, p2} = c[31:16];
        ins = c[7:0];
        o = ins inside {8'hb2, 8'hc0, 8'h12};
        acc = c[32] && (ins != 8'hc0 || pend);
        x = ins == 8'h88 ? 16'h9f0c : ins == 8'ha2 && p2[7:4] == 4'h1 ? 16'h9f01 :
            ins == 8'h32 ? 16'h9850 : ins == 8'hd6 ? 16'h9402 : 16'h9000;
        q = '{8'ha0, ins, (ins inside {8'hb2, 8'hdc} && p2 != 8'h04) ? 8'h00 : c[15:8], p2, p3};
        apb(1, 8'h04, c[31:0], r);
        for (int i = 0; acc && !o && i < p3; i++) begin
            q.push_back(8'($urandom));
            apb(1, 8'h08, {24'h0, q[$]}, r);
        end
        txq = {};
        apb(1, 8'h00, 32'h2, r);
        apb(1, 8'h00, 32'h1, r);
        repeat (300) begin
            apb(0, 8'h10, 0, st);
            if (st[18] | st[19]) break;
        end
        check("reject", st[19], !acc);
        check("done", st[18], acc);
        if (!acc) check("sent", txq.size(), 0);
        else begin
            check("status", st[15:0], x);
            check("pending", st[21], x[15:8] == 8'h9f);
            check("ok", st[20], x == 16'h9000);
            check("max", st[22], x == 16'h9850);
            check("range", st[23], x == 16'h9402);
            check("sent", txq.size(), q.size());
            foreach (q[i]) check("byte", txq[i], q[i]);
            for (int i = 0; o && i < p3; i++) begin
                apb(0, 8'h0c, 0, r);
                check("rdata", r, ins ^ i[7:0]);
            end
            pend = x[15:8] == 8'h9f;
            if (pend) apb(0, 8'h14, 0, r);
            if (pend) check("plen", r, x[7:0]);
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        logic [31:0] r;
        void'($urandom(96));
        repeat (3) @(posedge sys_clk);
        sys_rst <= 0;
        @(posedge sys_clk);
        apb(0, 8'h40, 0, r);
        check("unmapped", r, 0);
        foreach (cmds[i]) run(cmds[i]);
        give_verdict;
    end
    // a hang is cut after 20000 cycles
    initial begin
        #500000;
        errors++;
        give_verdict;
    end
endmodule // ccd_terminal_ctrl_tb
bind ccd_terminal_ctrl ccd_terminal_ctrl_asserts u_chk (.sys_clk, .sys_rst, .psel, .penable, .pready, .pslverr,
    .paddr, .cardTxByte, .cardTxValid, .cardTxReady, .busy, .cmdDone);
`default_nettype wire
